// File: design/csrac_top.sv
// control/status register bank with typed field access semantics
`timescale 1ns/100ps
`default_nettype none
module csrac_top #(
  parameter logic [7:0] SRST_LEN = csrac_pkg::SRST_CYCLES
) (
  input  wire logic         REF_CLK,
  input  wire logic         RST_N,
  input  wire logic [2:0]   SRC_REQ,
  input  wire logic [2:0]   SRC_WE,
  input  wire logic [2:0]   SRC_IO,
  input  wire logic [2:0]   SRC_WIDE,
  input  wire logic [11:0]  SRC_ADDR,
  input  wire logic [23:0]  SRC_BE,
  input  wire logic [191:0] SRC_WDATA,
  input  wire logic         EVENT_IN,
  input  wire logic [15:0]  CHIP_STATUS,
  output logic      [2:0]   SRC_GNT,
  output logic      [2:0]   ACK,
  output logic              ERR,
  output logic      [63:0]  RDATA,
  output logic      [7:0]   MODE_OUT,
  output logic              SOFT_RESET,
  output logic      [15:0]  CFG_OUT,
  output logic              CMD_STB,
  output logic      [31:0]  CMD_DATA,
  output logic              DL_START,
  output logic      [63:0]  DL_ADDR
);
  // ***************************************************
  // source selection
  // ***************************************************
  logic        acc_v;     // some source is granted
  logic        acc_we;    // write access
  logic        acc_io;    // i/o cycle
  logic        acc_wide;  // 64-bit access
  logic [3:0]  acc_idx;   // dword index
  logic [7:0]  acc_be;    // byte enables
  logic [63:0] acc_wd;    // write data
  logic        acc_ok;    // access is legal and mapped

  // three sources reach the same bank RL10
  csrac_arb #(.N(csrac_pkg::SRC_N), .AW(csrac_pkg::IDX_W), .DW(64)) u_arb (
    .req      (SRC_REQ),
    .we       (SRC_WE),
    .io       (SRC_IO),
    .wide     (SRC_WIDE),
    .addr     (SRC_ADDR),
    .be       (SRC_BE),
    .wdata    (SRC_WDATA),
    .gnt      (SRC_GNT),
    .sel_v    (acc_v),
    .sel_we   (acc_we),
    .sel_io   (acc_io),
    .sel_wide (acc_wide),
    .sel_addr (acc_idx),
    .sel_be   (acc_be),
    .sel_wdata(acc_wd)
  );

  // wide only on memory cycles at an even index RL12
  assign acc_ok = acc_v && (acc_idx <= csrac_pkg::IDX_LAST) &&
                  !(acc_wide && (acc_io || acc_idx[0]));  // RL11

  // ***************************************************
  // decode helpers
  // ***************************************************
  // byte lanes of the access that land in register r
  function automatic logic [3:0] lanes(input logic [3:0] r);
    if (!acc_ok || !acc_we) lanes = 4'h0;
    else if (acc_idx == r) lanes = acc_be[3:0];
    else if (acc_wide && (acc_idx + 4'h1) == r) lanes = acc_be[7:4];
    else lanes = 4'h0;
  endfunction

  // write data that lands in register r
  function automatic logic [31:0] wd_for(input logic [3:0] r);
    wd_for = (acc_wide && acc_idx != r) ? acc_wd[63:32] : acc_wd[31:0];
  endfunction

  // byte merge; disabled bytes keep their old value
  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                        input logic [31:0] new_v,
                                        input logic [3:0]  be);
    for (int b = 0; b < 4; b++) begin
      merge[b*8 +: 8] = be[b] ? new_v[b*8 +: 8] : old_v[b*8 +: 8];  // RL14
    end
  endfunction

  // ***************************************************
  // register state
  // ***************************************************
  logic [7:0]   mode_q, mode_d;        // stored mode field
  logic [31:0]  evcnt_q, evcnt_d;      // event counter
  logic [15:0]  cfg_q, cfg_d;          // r/w half of config
  logic [31:0]  dl_lsd_q, dl_lsd_d;    // list address low
  logic [31:0]  dl_msd_q, dl_msd_d;    // list address high
  logic [31:0]  cmd_q, cmd_d;          // last command word
  logic         cmd_stb_q, cmd_stb_d;  // command strobe
  logic         dl_go_q, dl_go_d;      // list start strobe
  csrac_pkg::csrac_srst_e srst_st_q, srst_st_d;  // self-clear state
  logic [7:0]   srst_cnt_q, srst_cnt_d;  // activity countdown
  logic [2:0]   ack_q, ack_d;          // per-source answer
  logic         err_q, err_d;          // refused access
  logic [63:0]  rdata_q, rdata_d;      // read data

  // read view of register r; write-only and unmapped read zero
  function automatic logic [31:0] rd_word(input logic [3:0] r);
    case (r)
      csrac_pkg::IDX_MODE:   rd_word = {24'h00_0000, mode_q};  // RL3
      csrac_pkg::IDX_EVCNT:  rd_word = evcnt_q;
      csrac_pkg::IDX_CFG:    rd_word = {CHIP_STATUS, cfg_q};   // RL1
      csrac_pkg::IDX_DL_LSD: rd_word = dl_lsd_q;
      csrac_pkg::IDX_DL_MSD: rd_word = dl_msd_q;
      default:               rd_word = 32'h0000_0000;          // RL1
    endcase
  endfunction

  // ***************************************************
  // next-state logic
  // ***************************************************
  logic [3:0]  ln_mode;   // lanes hitting mode
  logic [7:0]  sr_mask;   // set/reset mask
  logic        sr_ctrl;   // set/reset control bit
  logic        rd_evcnt;  // counter read this cycle
  logic        srst_set;  // host sets the self-clear bit
  logic [3:0]  ln_cfg;    // lanes hitting config
  logic [31:0] cfg_m;     // merged config word, high half dropped

  always_comb begin
    ln_mode  = lanes(csrac_pkg::IDX_MODE);
    sr_mask  = ln_mode[1] ? acc_wd[csrac_pkg::MODE_MASK_LSB +: csrac_pkg::MODE_W] : 8'h00;
    sr_ctrl  = ln_mode[2] & acc_wd[csrac_pkg::MODE_CTRL_BIT];
    srst_set = sr_mask[csrac_pkg::SRST_BIT] & sr_ctrl;
    rd_evcnt = acc_ok && !acc_we && (acc_idx == csrac_pkg::IDX_EVCNT ||
               (acc_wide && acc_idx + 4'h1 == csrac_pkg::IDX_EVCNT));
    // masked bits take the control value, others hold RL2
    mode_d = (mode_q & ~sr_mask) | (sr_mask & {8{sr_ctrl}});
    // self-clearing soft reset; a new host set restarts it RL4
    srst_st_d  = srst_st_q;
    srst_cnt_d = srst_cnt_q;
    case (srst_st_q)
      csrac_pkg::SRST_IDLE: begin
        if (srst_set) begin
          srst_st_d  = csrac_pkg::SRST_BUSY;
          srst_cnt_d = SRST_LEN;
        end
      end
      csrac_pkg::SRST_BUSY: begin
        if (srst_set) begin
          srst_cnt_d = SRST_LEN;
        end else if (srst_cnt_q <= 8'h01) begin
          srst_st_d = csrac_pkg::SRST_IDLE;
          mode_d[csrac_pkg::SRST_BIT] = 1'b0;  // RL4
        end else begin
          srst_cnt_d = srst_cnt_q - 8'h01;
        end
      end
      default: begin
        srst_st_d  = csrac_pkg::SRST_IDLE;
        srst_cnt_d = 8'h00;
      end
    endcase
    // clear on read; an event in the read cycle is kept RL5
    if (rd_evcnt) evcnt_d = csrac_pkg::EVCNT_RESTART + {31'h0000_0000, EVENT_IN};
    else evcnt_d = evcnt_q + {31'h0000_0000, EVENT_IN};
    // byte-enabled r/w fields; settings live here RL13
    ln_cfg   = lanes(csrac_pkg::IDX_CFG);
    // status half is read-only, so its lanes never merge RL1
    cfg_m    = merge({16'h0000, cfg_q}, wd_for(csrac_pkg::IDX_CFG), ln_cfg & 4'h3);
    cfg_d    = cfg_m[15:0];
    dl_lsd_d = merge(dl_lsd_q, wd_for(csrac_pkg::IDX_DL_LSD), lanes(csrac_pkg::IDX_DL_LSD));
    dl_msd_d = merge(dl_msd_q, wd_for(csrac_pkg::IDX_DL_MSD), lanes(csrac_pkg::IDX_DL_MSD));
    // lower dword write completes the 64-bit address RL8
    dl_go_d  = |lanes(csrac_pkg::IDX_DL_LSD);
    // write-only command register
    cmd_stb_d = |lanes(csrac_pkg::IDX_CMD);
    cmd_d     = cmd_stb_d ? merge(32'h0000_0000, wd_for(csrac_pkg::IDX_CMD),
                                  lanes(csrac_pkg::IDX_CMD)) : cmd_q;
    // answer: one cycle after the grant, to the granted source
    ack_d   = SRC_GNT;
    err_d   = acc_v && !acc_ok;  // RL12
    rdata_d = 64'h0000_0000_0000_0000;
    if (acc_ok && !acc_we) begin
      rdata_d[31:0]  = rd_word(acc_idx);                    // RL6
      rdata_d[63:32] = acc_wide ? rd_word(acc_idx + 4'h1) : 32'h0000_0000;
    end
  end

  // ***************************************************
  // state registers
  // ***************************************************
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      mode_q     <= csrac_pkg::MODE_RST;
      evcnt_q    <= csrac_pkg::EVCNT_RESTART;
      cfg_q      <= csrac_pkg::CFG_RST;
      dl_lsd_q   <= csrac_pkg::DL_RST;
      dl_msd_q   <= csrac_pkg::DL_RST;
      cmd_q      <= 32'h0000_0000;
      cmd_stb_q  <= 1'b0;
      dl_go_q    <= 1'b0;
      srst_st_q  <= csrac_pkg::SRST_IDLE;
      srst_cnt_q <= 8'h00;
      ack_q      <= 3'h0;
      err_q      <= 1'b0;
      rdata_q    <= 64'h0000_0000_0000_0000;
    end else begin
      mode_q     <= mode_d;
      evcnt_q    <= evcnt_d;
      cfg_q      <= cfg_d;
      dl_lsd_q   <= dl_lsd_d;
      dl_msd_q   <= dl_msd_d;
      cmd_q      <= cmd_d;
      cmd_stb_q  <= cmd_stb_d;
      dl_go_q    <= dl_go_d;
      srst_st_q  <= srst_st_d;
      srst_cnt_q <= srst_cnt_d;
      ack_q      <= ack_d;
      err_q      <= err_d;
      rdata_q    <= rdata_d;
    end
  end

  // outputs; the busy bits sit in the low half RL9
  assign ACK        = ack_q;
  assign ERR        = err_q;
  assign RDATA      = rdata_q;
  assign MODE_OUT   = mode_q;
  assign SOFT_RESET = mode_q[csrac_pkg::SRST_BIT];
  assign CFG_OUT    = cfg_q;
  assign CMD_STB    = cmd_stb_q;
  assign CMD_DATA   = cmd_q;
  assign DL_START   = dl_go_q;
  assign DL_ADDR    = {dl_msd_q, dl_lsd_q};

  // ***************************************************
  // checks
  // ***************************************************
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RST_N);
  localparam int SRST_MAX = 20;

  sequence srst_start_s;
    srst_set && srst_st_q == csrac_pkg::SRST_IDLE;
  endsequence
  sequence srst_done_s;
    !SOFT_RESET && srst_st_q == csrac_pkg::SRST_IDLE;
  endsequence

  mode_setreset_a: assert property (sr_mask != 8'h00 && srst_st_q == csrac_pkg::SRST_IDLE |=> // RL2
    ((MODE_OUT & $past(sr_mask)) == ($past(sr_mask) & {8{$past(sr_ctrl)}})))
    else $error("masked mode bits did not take control value");
  mode_readzero_a: assert property (acc_ok && !acc_we && acc_idx == csrac_pkg::IDX_MODE // RL3
    |=> RDATA[31:8] == 24'h00_0000 && RDATA[7:0] == $past(mode_q))
    else $error("mode read showed mask or control bits");
  srst_selfclr_a: assert property (srst_start_s ##1 !srst_set[*8] |-> // RL4
    SOFT_RESET ##[1:SRST_MAX] srst_done_s)
    else $error("self-clearing bit did not clear");
  evcnt_clear_a: assert property (rd_evcnt && !EVENT_IN |=> evcnt_q == 32'h0000_0000) // RL5
    else $error("counter not restarted after read");
  evcnt_value_a: assert property (acc_ok && !acc_we && !acc_wide && acc_idx == csrac_pkg::IDX_EVCNT // RL5
    |=> RDATA[31:0] == $past(evcnt_q))
    else $error("counter read returned wrong value");
  dl_start_a: assert property (DL_START |-> $past(acc_ok && acc_we && // RL8
    acc_idx == csrac_pkg::IDX_DL_LSD && acc_be[3:0] != 4'h0))
    else $error("list start without lower dword write");
  io_wide_a: assert property (acc_v && acc_io && acc_wide |=> ERR) // RL12
    else $error("64-bit i/o access not refused");
  unmapped_a: assert property (acc_v && acc_idx > csrac_pkg::IDX_LAST |=> ERR && RDATA == 64'h0) // RL11
    else $error("unmapped access not refused");
  cfg_bytekeep_a: assert property (!ln_cfg[0] |=> $stable(CFG_OUT[7:0])) // RL14
    else $error("unselected config byte changed");
  cmd_readzero_a: assert property (acc_ok && !acc_we && !acc_wide && acc_idx == csrac_pkg::IDX_CMD // RL1
    |=> RDATA == 64'h0 && !CMD_STB)
    else $error("write-only register read nonzero");
endmodule
`default_nettype wire

// File: design/csrac_pkg.sv
// constants for the control/status register access block
// Summary of operation
// RL1: each field is read/write, read-only or write-only
// RL2: masked set/reset write loads control bit
// RL3: mask and control positions read back zero
// RL4: self-clearing bit stays set until activity ends
// RL5: clear-on-read counter returns value then restarts
// RL6: registers 32 or 64 bits, I/O or memory
// RL7: host writes upper dword before lower dword
// RL8: lower dword write of list address starts operation
// RL9: busiest bits sit in low 16 bits
// RL10: PCI, EEPROM loader and internal blocks all access
// RL11: every register on a dword-aligned address
// RL12: 8/16/32/64-bit accesses; 64-bit memory cycles only
// RL13: operational settings held in control/status registers
// RL14: partial writes touch only enabled bytes; the command register zeroes its disabled bytes
package csrac_pkg;
  // ***************************************************
  // register map (dword index, byte address = index * 4)
  // ***************************************************
  localparam int unsigned IDX_W      = 4;
  localparam logic [3:0]  IDX_MODE   = 4'h0;  // set/reset mode register
  localparam logic [3:0]  IDX_EVCNT  = 4'h1;  // clear-on-read event counter
  localparam logic [3:0]  IDX_CFG    = 4'h2;  // low half r/w, high half status
  localparam logic [3:0]  IDX_CMD    = 4'h3;  // write-only command
  localparam logic [3:0]  IDX_DL_LSD = 4'h4;  // descriptor_list address, low
  localparam logic [3:0]  IDX_DL_MSD = 4'h5;  // descriptor_list address, high
  localparam logic [3:0]  IDX_LAST   = 4'h5;  // highest mapped index
  // ***************************************************
  // field layout of the mode register
  // ***************************************************
  localparam int unsigned MODE_W        = 8;   // stored field width
  localparam int unsigned MODE_MASK_LSB = 8;   // mask bits [15:8]
  localparam int unsigned MODE_CTRL_BIT = 16;  // control bit
  localparam int unsigned SRST_BIT      = 0;   // soft_reset_self_clear_bit
  // ***************************************************
  // reset values and counts
  // ***************************************************
  localparam logic [7:0]  MODE_RST      = 8'h00;
  localparam logic [15:0] CFG_RST       = 16'h0000;
  localparam logic [31:0] EVCNT_RESTART = 32'h0000_0000;
  localparam logic [31:0] DL_RST        = 32'h0000_0000;
  localparam logic [7:0]  SRST_CYCLES   = 8'h10;  // soft reset activity length
  // ***************************************************
  // access sources, index 0 wins arbitration
  // ***************************************************
  localparam int unsigned SRC_N      = 3;
  localparam int unsigned SRC_INT    = 0;
  localparam int unsigned SRC_EEPROM = 1;
  localparam int unsigned SRC_PCI    = 2;
  // self-clear activity states
  typedef enum logic [1:0] {
    SRST_IDLE = 2'b01,
    SRST_BUSY = 2'b10
  } csrac_srst_e;
endpackage

// File: design/csrac_arb.sv
// fixed-priority selector among the register access sources
`timescale 1ns/100ps
`default_nettype none
module csrac_arb #(
  parameter int unsigned N  = 3,
  parameter int unsigned AW = 4,
  parameter int unsigned DW = 64
) (
  input  wire logic [N-1:0]      req,
  input  wire logic [N-1:0]      we,
  input  wire logic [N-1:0]      io,
  input  wire logic [N-1:0]      wide,
  input  wire logic [N*AW-1:0]   addr,
  input  wire logic [N*DW/8-1:0] be,
  input  wire logic [N*DW-1:0]   wdata,
  output logic      [N-1:0]      gnt,
  output logic                   sel_v,
  output logic                   sel_we,
  output logic                   sel_io,
  output logic                   sel_wide,
  output logic      [AW-1:0]     sel_addr,
  output logic      [DW/8-1:0]   sel_be,
  output logic      [DW-1:0]     sel_wdata
);
  // lowest index wins; a loser simply keeps its request up
  always_comb begin
    gnt       = '0;
    sel_v     = 1'b0;
    sel_we    = 1'b0;
    sel_io    = 1'b0;
    sel_wide  = 1'b0;
    sel_addr  = '0;
    sel_be    = '0;
    sel_wdata = '0;
    for (int i = N - 1; i >= 0; i--) begin
      if (req[i]) begin  // later (lower) index overrides
        gnt       = '0;
        gnt[i]    = 1'b1;
        sel_v     = 1'b1;
        sel_we    = we[i];
        sel_io    = io[i];
        sel_wide  = wide[i];
        sel_addr  = addr[i*AW +: AW];
        sel_be    = be[i*DW/8 +: DW/8];
        sel_wdata = wdata[i*DW +: DW];
      end
    end
  end
endmodule
`default_nettype wire

// File: verif/csrac_host_model.sv
// requester model for one access source of the register bank
`timescale 1ns/100ps
`default_nettype none
module csrac_host_model (
  input  wire logic        clk,
  input  wire logic        gnt,
  input  wire logic        ack,
  input  wire logic        err,
  input  wire logic [63:0] rdata,
  output logic             req,
  output logic             we,
  output logic             io,
  output logic             wide,
  output logic      [3:0]  addr,
  output logic      [7:0]  be,
  output logic      [63:0] wdata
);
  logic [63:0] r_data;  // read data taken with the answer
  logic        r_err;   // refusal flag taken with the answer
  logic        r_ack;   // answer seen at the expected edge
  int          r_wait;  // edges waited for the grant
  // idle at time zero
  initial begin
    req = 1'b0;
    we = 1'b0;
    io = 1'b0;
    wide = 1'b0;
    addr = 4'h0;
    be = 8'h00;
    wdata = 64'h0;
  end
  // ***************************************************
  // one whole access, held until granted
  // ***************************************************
  // wide stays off for i/o unless a refusal case asks for it
  task automatic xfer(input logic w, input logic i, input logic wd, input logic [3:0] a,
                      input logic [7:0] b, input logic [63:0] d);
    r_wait = 0;
    @(posedge clk);
    #1;
    req = 1'b1;
    we = w;
    io = i;
    wide = wd;
    addr = a;
    be = b;
    wdata = d;
    // losing sources keep asking; bounded so a dead grant cannot hang us
    do begin
      @(posedge clk);
      r_wait++;
    end while (gnt !== 1'b1 && r_wait < 20);
    #1;
    req = 1'b0;
    // released address, byte-enable and data lines show the inverse; we, io and wide keep their value
    addr = ~a;
    be = ~b;
    wdata = ~d;
    @(posedge clk);
    r_ack = ack;
    r_err = err;
    r_data = rdata;
    // step off the answer edge so pulse counters have counted it
    #1;
  endtask
endmodule
`default_nettype wire

// File: verif/csrac_top_test.sv
// self-checking bench for the register access block
`timescale 1ns/100ps
`default_nettype none
module csrac_top_test;
  logic              clk, rst_n, ev;          // clock, reset, event pulse
  logic      [15:0]  status;                  // read-only status feed
  wire logic [2:0]   req, we, io, wide, gnt, ack;
  wire logic [11:0]  addr;
  wire logic [23:0]  be;
  wire logic [191:0] wdata;
  wire logic         err, srst, cmd_stb, dl_start;
  wire logic [63:0]  rdata, dl_addr;
  wire logic [7:0]   mode;
  wire logic [15:0]  cfg;
  wire logic [31:0]  cmd_data;
  int                err_total, comparisons, dl_hits, cmd_hits, srst_cnt;
  // short self-clear length keeps the run small
  csrac_top #(.SRST_LEN(8'h08)) uut (
    .REF_CLK(clk), .RST_N(rst_n), .SRC_REQ(req), .SRC_WE(we), .SRC_IO(io),
    .SRC_WIDE(wide), .SRC_ADDR(addr), .SRC_BE(be), .SRC_WDATA(wdata), .EVENT_IN(ev),
    .CHIP_STATUS(status), .SRC_GNT(gnt), .ACK(ack), .ERR(err), .RDATA(rdata),
    .MODE_OUT(mode), .SOFT_RESET(srst), .CFG_OUT(cfg), .CMD_STB(cmd_stb),
    .CMD_DATA(cmd_data), .DL_START(dl_start), .DL_ADDR(dl_addr));
  // source 0 internal, 1 loader, 2 pci host
  for (genvar g = 0; g < 3; g++) begin : src
    csrac_host_model host (
      .clk(clk), .gnt(gnt[g]), .ack(ack[g]), .err(err), .rdata(rdata), .req(req[g]),
      .we(we[g]), .io(io[g]), .wide(wide[g]), .addr(addr[4*g +: 4]),
      .be(be[8*g +: 8]), .wdata(wdata[64*g +: 64]));
  end
  // ***************************************************
  // clock, pulse counters, watchdog
  // ***************************************************
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // pulses are counted so one-cycle strobes are never missed
  always @(posedge clk) begin
    if (dl_start === 1'b1) dl_hits++;
    if (cmd_stb === 1'b1) cmd_hits++;
    if (srst === 1'b1) srst_cnt++;
  end
  initial begin
    #100000;
    err_total++;
    give_verdict();
  end
  // ***************************************************
  // shared helpers
  // ***************************************************
  task automatic chk(input string what, input logic [63:0] seen, input logic [63:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // pci memory write and read, answer must come without refusal
  task automatic wr(input logic [3:0] a, input logic [7:0] b, input logic [63:0] d);
    src[2].host.xfer(1'b1, 1'b0, 1'b0, a, b, d);
    chk("write answer", {src[2].host.r_ack, src[2].host.r_err}, 64'h2);
  endtask
  task automatic rd(input logic [3:0] a);
    src[2].host.xfer(1'b0, 1'b0, 1'b0, a, 8'h0F, 64'h0);
    chk("read answer", {src[2].host.r_ack, src[2].host.r_err}, 64'h2);
  endtask
  // ***************************************************
  // scenarios
  // ***************************************************
  task automatic t_reset();
    chk("mode reset", {56'h0, mode}, 64'h0);
    chk("cfg reset", {48'h0, cfg}, 64'h0);
    chk("list address reset", dl_addr, 64'h0);
    $display("test reset done");
  endtask
  // mask 0x90 with control one, then mask 0x10 with control zero
  task automatic t_mode();
    wr(csrac_pkg::IDX_MODE, 8'h06, 64'h0001_9000);
    chk("mode set", {56'h0, mode}, 64'h90);
    wr(csrac_pkg::IDX_MODE, 8'h06, 64'h0000_1000);
    chk("mode clear", {56'h0, mode}, 64'h80);
    rd(csrac_pkg::IDX_MODE);
    chk("mode read", src[2].host.r_data, 64'h80);
    $display("test mode done");
  endtask
  task automatic t_srst();
    srst_cnt = 0;
    wr(csrac_pkg::IDX_MODE, 8'h06, 64'h0001_0100);
    rd(csrac_pkg::IDX_MODE);
    chk("self clear busy", src[2].host.r_data, 64'h81);
    repeat (16) @(posedge clk);
    chk("self clear length", srst_cnt, 64'h8);
    rd(csrac_pkg::IDX_MODE);
    chk("self clear done", src[2].host.r_data, 64'h80);
    $display("test self clear done");
  endtask
  task automatic t_evcnt();
    rd(csrac_pkg::IDX_EVCNT);
    repeat (3) begin
      @(posedge clk);
      #1 ev = 1'b1;
      @(posedge clk);
      #1 ev = 1'b0;
    end
    rd(csrac_pkg::IDX_EVCNT);
    chk("event count", src[2].host.r_data, 64'h3);
    rd(csrac_pkg::IDX_EVCNT);
    chk("event restart", src[2].host.r_data, 64'h0);
    $display("test counter done");
  endtask
  // internal and loader writes, then a pci i/o read of the mixed register
  task automatic t_cfg();
    src[0].host.xfer(1'b1, 1'b0, 1'b0, csrac_pkg::IDX_CFG, 8'h03, 64'h0000_AABB);
    chk("cfg internal", {48'h0, cfg}, 64'hAABB);
    src[1].host.xfer(1'b1, 1'b0, 1'b0, csrac_pkg::IDX_CFG, 8'h02, 64'h0000_1234);
    chk("cfg byte lane", {48'h0, cfg}, 64'h12BB);
    status = 16'h5A3C;
    src[2].host.xfer(1'b0, 1'b1, 1'b0, csrac_pkg::IDX_CFG, 8'h0F, 64'h0);
    chk("cfg io read", src[2].host.r_data, 64'h5A3C_12BB);
    $display("test config done");
  endtask
  task automatic t_cmd();
    cmd_hits = 0;
    wr(csrac_pkg::IDX_CMD, 8'h03, 64'h1234_5678);
    chk("command strobe", cmd_hits, 64'h1);
    chk("command data", {32'h0, cmd_data}, 64'h5678);
    rd(csrac_pkg::IDX_CMD);
    chk("command read", src[2].host.r_data, 64'h0);
    $display("test command done");
  endtask
  // upper dword first; only the lower write launches the list
  task automatic t_dl();
    dl_hits = 0;
    wr(csrac_pkg::IDX_DL_MSD, 8'h0F, 64'hCAFE_0001);
    chk("no start on upper", dl_hits, 64'h0);
    wr(csrac_pkg::IDX_DL_LSD, 8'h0F, 64'h1000_0040);
    chk("start on lower", dl_hits, 64'h1);
    chk("list address", dl_addr, 64'hCAFE_0001_1000_0040);
    src[2].host.xfer(1'b1, 1'b0, 1'b1, csrac_pkg::IDX_DL_LSD, 8'hFF, 64'h0002_2000_0080);
    chk("wide start", dl_hits, 64'h2);
    chk("wide address", dl_addr, 64'h0002_2000_0080);
    src[2].host.xfer(1'b0, 1'b0, 1'b1, csrac_pkg::IDX_DL_LSD, 8'hFF, 64'h0);
    chk("wide read", src[2].host.r_data, 64'h0002_2000_0080);
    $display("test list done");
  endtask
  // wide i/o, wide at odd index, unmapped index
  task automatic t_refuse();
    for (int k = 0; k < 3; k++) begin
      src[2].host.xfer(1'b1, k == 0, k < 2, 4'(4 + k), 8'hFF, 64'hFFFF_FFFF);
      chk("refusal flag", src[2].host.r_err, 64'h1);
      chk("refusal data", src[2].host.r_data, 64'h0);
      chk("refusal no effect", dl_addr, 64'h0002_2000_0080);
    end
    $display("test refusal done");
  endtask
  // internal source wins, pci waits one more edge
  task automatic t_arb();
    fork
      src[0].host.xfer(1'b0, 1'b0, 1'b0, csrac_pkg::IDX_CFG, 8'h0F, 64'h0);
      src[2].host.xfer(1'b0, 1'b0, 1'b0, csrac_pkg::IDX_CFG, 8'h0F, 64'h0);
    join
    chk("internal first", src[0].host.r_wait, 64'h1);
    chk("pci second", src[2].host.r_wait, 64'h2);
    chk("pci read", src[2].host.r_data, 64'h5A3C_12BB);
    $display("test sharing done");
  endtask
  // ***************************************************
  // main sequence
  // ***************************************************
  initial begin
    rst_n = 1'b0;
    ev = 1'b0;
    status = 16'h0000;
    repeat (12) @(posedge clk);
    #1 rst_n = 1'b1;
    t_reset();
    t_mode();
    t_srst();
    t_evcnt();
    t_cfg();
    t_cmd();
    t_dl();
    t_refuse();
    t_arb();
    give_verdict();
  end
endmodule
`default_nettype wire
